// file: dv/capacitive_divider_sequencer_bench.sv
`timescale 1ns/1ps
module capacitive_divider_sequencer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic trig = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, cmp, flag, busy;
  logic [7:0] q, sec_oe;
  logic [63:0] gl;
  cvd_pkg::cvd_hold_t hold;
  cvd_pkg::cvd_route_t route;
  cvd_pkg::cvd_pin_t pin, ga, gb;
  int err_count = 0;
  int checks_done = 0;
  int cyc_cnt = 0;
  int n;

  initial forever #5 clk_i = ~clk_i;

  cvd_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trig_i(trig), .cmp_i(cmp), .hold_o(hold), .route_o(route),
    .chan_pin_o(pin), .sec_pin_level_o(), .sec_pin_oe_n_o(sec_oe), .guard_a_o(ga),
    .guard_b_o(gb), .conv_done_flag_o(flag), .busy_o(busy));
  cvd_sensor_model sensor (.clk_i(clk_i), .pin_i(pin), .cmp_o(cmp));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {18'h0, idx, 2'h0};
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] idx, input logic [9:0] exp);
    wb(1'b0, idx, 8'h00);
    chk({2'h0, q}, exp);
  endtask

  // Busy length in cycles, with the guard A level of every cycle kept in gl.
  task automatic measure;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 60) begin
      gl[n] = ga.level;
      n++;
      @(posedge clk_i);
      #1;
    end
  endtask

  task automatic double_run;
    wb(1'b1, cvd_pkg::IDX_CON0, 8'h01);
    wb(1'b1, cvd_pkg::IDX_PRE, 8'h03);
    wb(1'b1, cvd_pkg::IDX_ACQ, 8'h01);
    wb(1'b1, cvd_pkg::IDX_CON3, 8'h41);
    wb(1'b1, cvd_pkg::IDX_GRD, 8'hC0);
    @(posedge clk_i);
    #1;
    chk({ga.oe_n, gb.oe_n}, 2'h0);
    wb(1'b1, cvd_pkg::IDX_CON0, 8'h03);
    measure();
    chk(10'(n), 10'd30);
    chk({gl[0], gl[3], gl[16], gl[19]}, 4'h6);
    rd(cvd_pkg::IDX_RES0L, 10'h000);
    rd(cvd_pkg::IDX_RES1L, 10'h0FF);
    rd(cvd_pkg::IDX_RES1H, 10'h003);
    rd(cvd_pkg::IDX_CON0, 10'h001);
    rd(cvd_pkg::IDX_CON3, 10'h041);
    chk(flag, 1'b1);
    wb(1'b1, cvd_pkg::IDX_SHARED, 8'h02);
    #1;
    chk(flag, 1'b0);
  endtask

  task automatic alias_and_channels;
    wb(1'b1, cvd_pkg::IDX_L_CON0, 8'h05);
    rd(cvd_pkg::IDX_CON0, 10'h005);
    rd(cvd_pkg::IDX_L_RES0H, 10'h000);
    wb(1'b1, cvd_pkg::IDX_CH, 8'h03);
    @(posedge clk_i);
    #1;
    chk({route.chan_sel, route.sec_conn[4:0]}, 10'h023);
    chk({2'h0, sec_oe}, 10'h0FF);
    rd(12'h123, 10'h000);
  endtask

  task automatic abort_run;
    wb(1'b1, cvd_pkg::IDX_CON3, 8'h20);
    wb(1'b1, cvd_pkg::IDX_CON0, 8'h07);
    repeat (6) @(posedge clk_i);
    wb(1'b1, cvd_pkg::IDX_CON0, 8'h05);
    @(posedge clk_i);
    #1;
    chk(busy, 1'b0);
    rd(cvd_pkg::IDX_RES0L, 10'h0FF);
    rd(cvd_pkg::IDX_RES0H, 10'h003);
  endtask

  task automatic other_starts;
    wb(1'b1, cvd_pkg::IDX_CON2, 8'h01);
    @(posedge clk_i);
    trig <= 1'b1;
    @(posedge clk_i);
    trig <= 1'b0;
    measure();
    chk(10'(n), 10'd14);
    wb(1'b1, cvd_pkg::IDX_CON2, 8'h00);
    wb(1'b1, cvd_pkg::IDX_SHARED, 8'h01);
    measure();
    chk(10'(n), 10'd14);
    rd(cvd_pkg::IDX_SHARED, 10'h002);
  endtask

  task automatic results;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hung handshake ends the run rather than stalling it.
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cvd_pkg::IDX_STAT, 10'h000);
    double_run();
    alias_and_channels();
    abort_run();
    other_starts();
    results();
  end
endmodule

// file: dv/cvd_sensor_model.sv
`timescale 1ns/1ps
module cvd_sensor_model (
  // Clock
  input wire logic clk_i,
  // Sensor pin and comparator
  input wire cvd_pkg::cvd_pin_t pin_i,
  output logic cmp_o
);
  // The node keeps the charge of the last precharge, so the comparator is steady.
  initial cmp_o = 1'b0;
  always @(posedge clk_i) begin
    if (pin_i.oe_n == 1'b0) begin
      cmp_o <= pin_i.level;
    end
  end
endmodule

// file: inc/cvd_pkg.sv
package cvd_pkg;
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [11:0] IDX_CON0 = 12'h711;
  localparam logic [11:0] IDX_CON1 = 12'h712;
  localparam logic [11:0] IDX_CON2 = 12'h713;
  localparam logic [11:0] IDX_CON3 = 12'h714;
  localparam logic [11:0] IDX_STAT = 12'h715;
  localparam logic [11:0] IDX_PRE = 12'h716;
  localparam logic [11:0] IDX_ACQ = 12'h717;
  localparam logic [11:0] IDX_GRD = 12'h718;
  localparam logic [11:0] IDX_CAP = 12'h719;
  localparam logic [11:0] IDX_RES0L = 12'h71A;
  localparam logic [11:0] IDX_RES0H = 12'h71B;
  localparam logic [11:0] IDX_RES1L = 12'h71C;
  localparam logic [11:0] IDX_RES1H = 12'h71D;
  localparam logic [11:0] IDX_CH = 12'h71E;
  localparam logic [11:0] IDX_SHARED = 12'h71F;
  // Legacy converter registers in the low bank.
  localparam logic [11:0] IDX_L_CON0 = 12'h09D;
  localparam logic [11:0] IDX_L_CON1 = 12'h09E;
  localparam logic [11:0] IDX_L_CON2 = 12'h09F;
  localparam logic [11:0] IDX_L_RES0L = 12'h09B;
  localparam logic [11:0] IDX_L_RES0H = 12'h09C;
  // Field positions.
  localparam int CON0_ON = 0;
  localparam int CON0_GO = 1;
  localparam int CON0_CHS_LSB = 2;
  localparam int CON0_CHS_MSB = 6;
  localparam int CON2_TRIG_EN = 0;
  localparam int CON3_INV = 0;
  localparam int CON3_IPOL = 1;
  localparam int CON3_EPOL = 5;
  localparam int CON3_DSE = 6;
  localparam int GRD_POL = 0;
  localparam int GRD_B_EN = 6;
  localparam int GRD_A_EN = 7;
  localparam int SH_GO = 0;
  localparam int SH_FLAG = 1;
  localparam int TIME_MSB = 6;
  localparam int CAP_MSB = 3;
  localparam int RES_BITS = 10;
  // Timing in clock cycles.
  localparam logic [6:0] CNT_ONE = 7'h01;
  localparam logic [6:0] GAP_CYCLES = 7'h02;
  // Stage codes shown in the status register.
  localparam logic [2:0] STG_IDLE = 3'h0;
  localparam logic [2:0] STG_PRE = 3'h1;
  localparam logic [2:0] STG_ACQ = 3'h2;
  localparam logic [2:0] STG_CONV = 3'h3;
  localparam logic [2:0] STG_GAP = 3'h4;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [2:0] {S_IDLE, S_PRE, S_ACQ, S_CONV, S_GAP} cvd_state_t;

  typedef struct packed {
    logic hold_tie;
    logic hold_level;
    logic mux_open;
    logic sample_conn;
    logic [3:0] extra_cap;
  } cvd_hold_t;

  typedef struct packed {
    logic [4:0] chan_sel;
    logic chan_conn;
    logic [7:0] sec_conn;
  } cvd_route_t;

  typedef struct packed {
    logic level;
    logic oe_n;
  } cvd_pin_t;
endpackage

// file: logic/cvd_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - At the end of the run (its last conversion) clear the start/busy bit, and the shared bit if used.
// - Each finished conversion sets the done flag.
// - Each finished conversion loads the result registers.
// - Clearing busy early stops the run; in the conversion stage it also stores a partial result, gaps filled with last bit.
// - Reset returns every register to reset, turning off and aborting.
// - With double sampling, each start request yields two conversions.
// - In double sampling busy stays set until the second conversion ends.
// - Without invert, both conversions use identical polarities.
// - First result goes to set 0, second to set 1.
// - Second conversion begins two cycles after the first ends.
// - With invert, second conversion inverts external, internal and guard polarity only.
// - Two guard outputs, each with own enable, polarity from guard polarity bit.
// - Guards drive continuously while enabled and the converter is on.
// - Guards take polarity at precharge start and toggle at acquisition start.
// - With double sampling and invert, second-phase guard levels are inverted.
// - A 4-bit field adds hold capacitance, removed during conversion.
// - Each secondary channel bit connects that channel to the sampling bus.
// - Secondary channels are inputs but copy the primary precharge drive.
// - Channels connect as soon as select bits are written.
// - Legacy low-bank addresses alias control registers CON0-CON2 and the result-set-0 registers.
// - A status register shows the current sequencer stage.
// - Non-zero precharge count inserts that many precharge cycles; zero skips.
// - Precharge ties hold capacitor, opens mux, drives pin to external polarity.
// - Non-zero acquisition count runs acquisition with drivers off, channel connected.
// - A conversion halts when the converter on bit is cleared.
module cvd_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Start sources and comparator
  input wire logic trig_i,
  input wire logic cmp_i,
  // Analog front end
  output cvd_pkg::cvd_hold_t hold_o,
  output cvd_pkg::cvd_route_t route_o,
  output cvd_pkg::cvd_pin_t chan_pin_o,
  output logic [7:0] sec_pin_level_o,
  output logic [7:0] sec_pin_oe_n_o,
  // Guard outputs
  output cvd_pkg::cvd_pin_t guard_a_o,
  output cvd_pkg::cvd_pin_t guard_b_o,
  // Status
  output logic conv_done_flag_o,
  output logic busy_o
);
  logic [7:0] con0_r, con1_r, con2_r, con3_r, pre_r, acq_r, grd_r, cap_r, ch_r;
  logic [cvd_pkg::RES_BITS-1:0] res0_r, res1_r, sar_r, sar_full, partial_res;
  logic shared_go_r, flag_r, ack_r, second_r, second_nxt, guard_lvl_r, guard_lvl_nxt;
  logic cmp_m_r, cmp_s_r;
  logic [31:0] dat_r;
  logic [6:0] cnt_r;
  cvd_pkg::cvd_state_t state_r, state_nxt;
  logic [11:0] idx;
  logic req, wr, start_req, abort, halt, conv_done, run_end, inv, inv_nxt;
  logic eff_ext_nxt, eff_int_nxt, eff_grd_nxt, eff_grd;
  logic [7:0] wd, rd;

  function automatic logic [11:0] map_idx(input logic [11:0] a);
    case (a)
      cvd_pkg::IDX_L_CON0: map_idx = cvd_pkg::IDX_CON0;
      cvd_pkg::IDX_L_CON1: map_idx = cvd_pkg::IDX_CON1;
      cvd_pkg::IDX_L_CON2: map_idx = cvd_pkg::IDX_CON2;
      cvd_pkg::IDX_L_RES0L: map_idx = cvd_pkg::IDX_RES0L;
      cvd_pkg::IDX_L_RES0H: map_idx = cvd_pkg::IDX_RES0H;
      default: map_idx = a;
    endcase
  endfunction

  // Bits at and below position k were never resolved; they repeat the last resolved bit.
  function automatic logic [cvd_pkg::RES_BITS-1:0] fill_partial(
    input logic [cvd_pkg::RES_BITS-1:0] sar, input logic [6:0] k);
    logic fillv;
    fill_partial = '0;
    fillv = (int'(k) == cvd_pkg::RES_BITS - 1) ? 1'b0 : sar[0];
    for (int p = 0; p < cvd_pkg::RES_BITS; p++) begin
      if (p > int'(k)) begin
        fill_partial[p] = sar[p - int'(k) - 1];
      end else begin
        fill_partial[p] = fillv;
      end
    end
  endfunction

  function automatic cvd_pkg::cvd_state_t first_stage(input logic [7:0] p, input logic [7:0] a);
    if (p[cvd_pkg::TIME_MSB:0] != '0) begin
      first_stage = cvd_pkg::S_PRE;
    end else if (a[cvd_pkg::TIME_MSB:0] != '0) begin
      first_stage = cvd_pkg::S_ACQ;
    end else begin
      first_stage = cvd_pkg::S_CONV;
    end
  endfunction

  function automatic logic [2:0] stage_code(input cvd_pkg::cvd_state_t s);
    case (s)
      cvd_pkg::S_PRE: stage_code = cvd_pkg::STG_PRE;
      cvd_pkg::S_ACQ: stage_code = cvd_pkg::STG_ACQ;
      cvd_pkg::S_CONV: stage_code = cvd_pkg::STG_CONV;
      cvd_pkg::S_GAP: stage_code = cvd_pkg::STG_GAP;
      default: stage_code = cvd_pkg::STG_IDLE;
    endcase
  endfunction

  // Bus decode; both banks reach the same storage.
  assign idx = map_idx(wb_adr_i[13:2]);
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & ack_r & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  // The comparator is analog-timed, so it is synchronised before the SAR reads it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_m_r <= 1'b0;
      cmp_s_r <= 1'b0;
    end else begin
      cmp_m_r <= cmp_i;
      cmp_s_r <= cmp_m_r;
    end
  end

  assign start_req = (state_r == cvd_pkg::S_IDLE) && con0_r[cvd_pkg::CON0_ON] &&
      ((wr && idx == cvd_pkg::IDX_CON0 && wd[cvd_pkg::CON0_GO]) ||
       (wr && idx == cvd_pkg::IDX_SHARED && wd[cvd_pkg::SH_GO]) ||
       (trig_i && con2_r[cvd_pkg::CON2_TRIG_EN]));
  assign abort = (state_r != cvd_pkg::S_IDLE) &&
      ((wr && idx == cvd_pkg::IDX_CON0 && !wd[cvd_pkg::CON0_GO]) ||
       (wr && idx == cvd_pkg::IDX_SHARED && shared_go_r && !wd[cvd_pkg::SH_GO]));
  assign halt = (state_r != cvd_pkg::S_IDLE) && !con0_r[cvd_pkg::CON0_ON];
  assign conv_done = (state_r == cvd_pkg::S_CONV) && (cnt_r == '0) && !abort && !halt;
  assign run_end = (conv_done && !(con3_r[cvd_pkg::CON3_DSE] && !second_r)) ||
      abort || halt;
  assign sar_full = {sar_r[cvd_pkg::RES_BITS-2:0], cmp_s_r};
  assign partial_res = fill_partial(sar_r, cnt_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cvd_pkg::S_IDLE: begin
        if (start_req) begin
          state_nxt = first_stage(pre_r, acq_r);
        end
      end
      cvd_pkg::S_PRE: begin
        if (cnt_r == '0) begin
          state_nxt = (acq_r[cvd_pkg::TIME_MSB:0] != '0) ? cvd_pkg::S_ACQ : cvd_pkg::S_CONV;
        end
      end
      cvd_pkg::S_ACQ: begin
        if (cnt_r == '0) begin
          state_nxt = cvd_pkg::S_CONV;
        end
      end
      cvd_pkg::S_CONV: begin
        if (cnt_r == '0) begin
          state_nxt = run_end ? cvd_pkg::S_IDLE : cvd_pkg::S_GAP;
        end
      end
      cvd_pkg::S_GAP: begin
        if (cnt_r == '0) begin
          state_nxt = first_stage(pre_r, acq_r);
        end
      end
      default: state_nxt = cvd_pkg::S_IDLE;
    endcase
    if (abort || halt) begin
      state_nxt = cvd_pkg::S_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= cvd_pkg::S_IDLE;
      cnt_r <= '0;
      second_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      second_r <= second_nxt;
      if (state_nxt != state_r) begin
        case (state_nxt)
          cvd_pkg::S_PRE: cnt_r <= pre_r[cvd_pkg::TIME_MSB:0] - cvd_pkg::CNT_ONE;
          cvd_pkg::S_ACQ: cnt_r <= acq_r[cvd_pkg::TIME_MSB:0] - cvd_pkg::CNT_ONE;
          cvd_pkg::S_CONV: cnt_r <= 7'(cvd_pkg::RES_BITS - 1);
          cvd_pkg::S_GAP: cnt_r <= cvd_pkg::GAP_CYCLES - cvd_pkg::CNT_ONE;
          default: cnt_r <= '0;
        endcase
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - cvd_pkg::CNT_ONE;
      end
    end
  end

  assign second_nxt = (state_nxt == cvd_pkg::S_GAP) ||
      (second_r && state_nxt != cvd_pkg::S_IDLE);

  // Successive approximation: one bit a cycle, most significant first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sar_r <= '0;
    end else if (state_r == cvd_pkg::S_CONV) begin
      sar_r <= sar_full;
    end else begin
      sar_r <= '0;
    end
  end

  // Only the polarity actually used is inverted; the stored bits stay as written.
  assign inv = second_r && con3_r[cvd_pkg::CON3_DSE] && con3_r[cvd_pkg::CON3_INV];
  assign inv_nxt = second_nxt && con3_r[cvd_pkg::CON3_DSE] && con3_r[cvd_pkg::CON3_INV];
  assign eff_ext_nxt = con3_r[cvd_pkg::CON3_EPOL] ^ inv_nxt;
  assign eff_int_nxt = con3_r[cvd_pkg::CON3_IPOL] ^ inv_nxt;
  assign eff_grd_nxt = grd_r[cvd_pkg::GRD_POL] ^ inv_nxt;
  assign eff_grd = grd_r[cvd_pkg::GRD_POL] ^ inv;

  // Control registers; software writes, with the start/busy bit owned by the sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      con0_r <= cvd_pkg::REG_RST;
      shared_go_r <= 1'b0;
    end else begin
      if (wr && idx == cvd_pkg::IDX_CON0) begin
        con0_r[cvd_pkg::CON0_CHS_MSB:cvd_pkg::CON0_CHS_LSB] <=
            wd[cvd_pkg::CON0_CHS_MSB:cvd_pkg::CON0_CHS_LSB];
        con0_r[cvd_pkg::CON0_ON] <= wd[cvd_pkg::CON0_ON];
      end
      if (run_end) begin
        con0_r[cvd_pkg::CON0_GO] <= 1'b0;
        shared_go_r <= 1'b0;
      end else if (start_req) begin
        con0_r[cvd_pkg::CON0_GO] <= 1'b1;
        shared_go_r <= wr && idx == cvd_pkg::IDX_SHARED;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      con1_r <= cvd_pkg::REG_RST;
      con2_r <= cvd_pkg::REG_RST;
      con3_r <= cvd_pkg::REG_RST;
      pre_r <= cvd_pkg::REG_RST;
      acq_r <= cvd_pkg::REG_RST;
      grd_r <= cvd_pkg::REG_RST;
      cap_r <= cvd_pkg::REG_RST;
      ch_r <= cvd_pkg::REG_RST;
    end else if (wr) begin
      case (idx)
        cvd_pkg::IDX_CON1: con1_r <= wd;
        cvd_pkg::IDX_CON2: con2_r <= wd;
        cvd_pkg::IDX_CON3: con3_r <= wd;
        cvd_pkg::IDX_PRE: pre_r <= {1'b0, wd[cvd_pkg::TIME_MSB:0]};
        cvd_pkg::IDX_ACQ: acq_r <= {1'b0, wd[cvd_pkg::TIME_MSB:0]};
        cvd_pkg::IDX_GRD: grd_r <= wd;
        cvd_pkg::IDX_CAP: cap_r <= {4'h0, wd[cvd_pkg::CAP_MSB:0]};
        cvd_pkg::IDX_CH: ch_r <= wd;
        default: ;
      endcase
    end
  end

  // Hardware result updates win over a software write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res0_r <= '0;
      res1_r <= '0;
    end else if (conv_done) begin
      if (second_r) begin
        res1_r <= sar_full;
      end else begin
        res0_r <= sar_full;
      end
    end else if (abort && state_r == cvd_pkg::S_CONV) begin
      if (second_r) begin
        res1_r <= partial_res;
      end else begin
        res0_r <= partial_res;
      end
    end else if (wr) begin
      case (idx)
        cvd_pkg::IDX_RES0L: res0_r[7:0] <= wd;
        cvd_pkg::IDX_RES0H: res0_r[cvd_pkg::RES_BITS-1:8] <= wd[cvd_pkg::RES_BITS-9:0];
        cvd_pkg::IDX_RES1L: res1_r[7:0] <= wd;
        cvd_pkg::IDX_RES1H: res1_r[cvd_pkg::RES_BITS-1:8] <= wd[cvd_pkg::RES_BITS-9:0];
        default: ;
      endcase
    end
  end

  // Done flag: a new completion wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (conv_done) begin
      flag_r <= 1'b1;
    end else if (wr && idx == cvd_pkg::IDX_SHARED && wd[cvd_pkg::SH_FLAG]) begin
      flag_r <= 1'b0;
    end
  end

  always_comb begin
    case (idx)
      cvd_pkg::IDX_CON0: rd = con0_r;
      cvd_pkg::IDX_CON1: rd = con1_r;
      cvd_pkg::IDX_CON2: rd = con2_r;
      cvd_pkg::IDX_CON3: rd = con3_r;
      cvd_pkg::IDX_STAT: rd = {4'h0, second_r, stage_code(state_r)};
      cvd_pkg::IDX_PRE: rd = pre_r;
      cvd_pkg::IDX_ACQ: rd = acq_r;
      cvd_pkg::IDX_GRD: rd = grd_r;
      cvd_pkg::IDX_CAP: rd = cap_r;
      cvd_pkg::IDX_RES0L: rd = res0_r[7:0];
      cvd_pkg::IDX_RES0H: rd = {6'h00, res0_r[cvd_pkg::RES_BITS-1:8]};
      cvd_pkg::IDX_RES1L: rd = res1_r[7:0];
      cvd_pkg::IDX_RES1H: rd = {6'h00, res1_r[cvd_pkg::RES_BITS-1:8]};
      cvd_pkg::IDX_CH: rd = ch_r;
      cvd_pkg::IDX_SHARED: rd = {6'h00, flag_r, shared_go_r};
      default: rd = 8'h00;
    endcase
  end

  // Every access, mapped or not, is acknowledged one cycle after the strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r <= {24'h00_0000, rd};
      end
    end
  end

  // Front-end controls are registered from the next state so they line up with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_o <= '0;
      route_o <= '0;
      chan_pin_o <= '{level: 1'b0, oe_n: 1'b1};
      sec_pin_level_o <= 8'h00;
      sec_pin_oe_n_o <= 8'hFF;
    end else begin
      hold_o.hold_tie <= state_nxt == cvd_pkg::S_PRE;
      hold_o.hold_level <= eff_int_nxt;
      hold_o.mux_open <= state_nxt == cvd_pkg::S_PRE;
      hold_o.sample_conn <= con0_r[cvd_pkg::CON0_ON] && state_nxt != cvd_pkg::S_PRE &&
          state_nxt != cvd_pkg::S_CONV;
      hold_o.extra_cap <= (state_nxt == cvd_pkg::S_CONV) ? 4'h0 :
          cap_r[cvd_pkg::CAP_MSB:0];
      route_o.chan_sel <= con0_r[cvd_pkg::CON0_CHS_MSB:cvd_pkg::CON0_CHS_LSB];
      route_o.chan_conn <= con0_r[cvd_pkg::CON0_ON] && state_nxt != cvd_pkg::S_PRE;
      route_o.sec_conn <= ch_r & {8{con0_r[cvd_pkg::CON0_ON] &&
          state_nxt != cvd_pkg::S_PRE}};
      chan_pin_o.level <= eff_ext_nxt;
      chan_pin_o.oe_n <= state_nxt != cvd_pkg::S_PRE;
      sec_pin_level_o <= {8{eff_ext_nxt}};
      sec_pin_oe_n_o <= ~(ch_r & {8{state_nxt == cvd_pkg::S_PRE}});
    end
  end

  // Guard level follows the phase boundaries and holds between runs.
  always_comb begin
    guard_lvl_nxt = guard_lvl_r;
    if (state_nxt == cvd_pkg::S_PRE && state_r != cvd_pkg::S_PRE) begin
      guard_lvl_nxt = eff_grd_nxt;
    end else if (state_nxt == cvd_pkg::S_ACQ && state_r != cvd_pkg::S_ACQ) begin
      guard_lvl_nxt = !eff_grd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_lvl_r <= 1'b0;
    end else begin
      guard_lvl_r <= guard_lvl_nxt;
    end
  end

  // The pins take the next level so they switch with the phase, not a cycle after it.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_a_o <= '{level: 1'b0, oe_n: 1'b1};
      guard_b_o <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      guard_a_o.level <= guard_lvl_nxt;
      guard_b_o.level <= guard_lvl_nxt;
      guard_a_o.oe_n <= !(con0_r[cvd_pkg::CON0_ON] && grd_r[cvd_pkg::GRD_A_EN]);
      guard_b_o.oe_n <= !(con0_r[cvd_pkg::CON0_ON] && grd_r[cvd_pkg::GRD_B_EN]);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign conv_done_flag_o = flag_r;
  assign busy_o = con0_r[cvd_pkg::CON0_GO];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_first_done;
    conv_done && !run_end;
  endsequence
  sequence s_quiet_gap;
    (state_r == cvd_pkg::S_GAP && !abort && !halt) [*2];
  endsequence

  chk_busy_clear: assert property (run_end |=> !con0_r[cvd_pkg::CON0_GO] && !shared_go_r)
    else $error("Busy bit not cleared at end of run.");
  chk_flag_set: assert property (conv_done |=> flag_r)
    else $error("Done flag not set after conversion.");
  chk_result_set0: assert property (conv_done && !second_r |=> res0_r == $past(sar_full))
    else $error("Result set 0 not loaded.");
  chk_result_set1: assert property (conv_done && second_r |=> res1_r == $past(sar_full))
    else $error("Result set 1 not loaded.");
  chk_abort_fill: assert property (abort && state_r == cvd_pkg::S_CONV && !second_r
      |=> res0_r == $past(partial_res) && state_r == cvd_pkg::S_IDLE)
    else $error("Partial result not stored on abort.");
  chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> state_r == cvd_pkg::S_IDLE && con0_r == cvd_pkg::REG_RST)
    else $error("Reset did not return sequencer to idle.");
  chk_gap_second: assert property (s_first_done |=> s_quiet_gap ##1
      (state_r != cvd_pkg::S_GAP && state_r != cvd_pkg::S_IDLE && second_r &&
       con0_r[cvd_pkg::CON0_GO]))
    else $error("Second conversion did not start two cycles after the first.");
  chk_precharge_skip: assert property (start_req |=>
      (state_r == cvd_pkg::S_PRE) == ($past(pre_r) != cvd_pkg::REG_RST))
    else $error("Precharge stage entry does not match precharge count.");
  chk_guard_toggle: assert property ($rose(state_r == cvd_pkg::S_ACQ) |->
      guard_lvl_r == !eff_grd && guard_a_o.level == guard_lvl_r && guard_b_o.level == guard_lvl_r)
    else $error("Guard level did not toggle at acquisition start.");
  chk_cap_off: assert property (state_r == cvd_pkg::S_CONV |-> hold_o.extra_cap == 4'h0)
    else $error("Extra capacitance connected during conversion.");
  chk_halt_off: assert property (!con0_r[cvd_pkg::CON0_ON] |=> state_r == cvd_pkg::S_IDLE)
    else $error("Conversion kept running with converter off.");
  chk_invert_pin: assert property (state_r == cvd_pkg::S_PRE && $stable(con3_r) |->
      chan_pin_o.level == (con3_r[cvd_pkg::CON3_EPOL] ^ inv) && !chan_pin_o.oe_n)
    else $error("Precharge pin drive has wrong polarity.");
endmodule
